/* include/kbh_pkg.sv */
package kbh_pkg;
  localparam logic [7:0] KBH_PORT_DATA      = 8'h60;
  localparam logic [7:0] KBH_PORT_STATUS    = 8'h64;
  // Avalon word offsets of the software registers.
  localparam logic [3:0] KBH_OFF_DATA       = 4'h0;
  localparam logic [3:0] KBH_OFF_STATUS     = 4'h1;
  localparam logic [3:0] KBH_OFF_KEYBOARD_CONTROL_REGISTER    = 4'h2;
  localparam logic [3:0] KBH_OFF_MISC       = 4'h3;
  localparam logic [3:0] KBH_OFF_MGMT       = 4'h4;
  localparam logic [3:0] KBH_OFF_MCU_OUT    = 4'h5;
  localparam logic [3:0] KBH_OFF_MCU_IN     = 4'h6;
  localparam logic [3:0] KBH_OFF_RAM_ADDR   = 4'h7;
  localparam logic [3:0] KBH_OFF_RAM_DATA   = 4'h8;
  localparam logic [3:0] KBH_OFF_PORTS      = 4'h9;
  localparam logic [3:0] KBH_OFF_SERIAL     = 4'ha;
  localparam int         KBH_BIT_OBF        = 0;
  localparam int         KBH_BIT_IBF        = 1;
  localparam int         KBH_BIT_SYS        = 2;
  localparam int         KBH_BIT_CMD        = 3;
  localparam int         KBH_BIT_KBEN       = 4;
  localparam int         KBH_BIT_PERS       = 1;
  localparam int         KBH_BIT_QUICK      = 5;
  localparam int         KBH_BIT_MGMT       = 7;
  localparam logic [7:0] KBH_STATUS_RST     = 8'h10;
  localparam logic [7:0] KBH_OUTPORT_RST    = 8'h02;
  localparam logic [7:0] KBH_CMD_PULSE      = 8'hfe;
  localparam logic [7:0] KBH_CMD_GATE       = 8'hd1;
  localparam int         KBH_GATE_BIT       = 1;
  localparam int         KBH_CLK_MHZ_X100   = 2000;
  localparam int         KBH_DELAY_NS       = 50000;
  localparam int         KBH_PULSE_NS       = 6000;
  localparam int         KBH_QUICK_NS       = 6720;
  localparam int         KBH_DELAY_CYC      = KBH_DELAY_NS * KBH_CLK_MHZ_X100 / 100000;
  localparam int         KBH_PULSE_CYC      = KBH_PULSE_NS * KBH_CLK_MHZ_X100 / 100000;
  localparam int         KBH_QUICK_CYC      = KBH_QUICK_NS * KBH_CLK_MHZ_X100 / 100000;
  localparam int         KBH_TIMEOUT_TICKS  = 255;
  localparam logic [7:0] KBH_TO_KBD_TX      = 8'hfe;
  localparam logic [7:0] KBH_TO_KBD_RX      = 8'hff;
  typedef enum logic [1:0] {KBH_RST_IDLE, KBH_RST_WAIT, KBH_RST_PULSE} kbh_rst_e;
endpackage

/* include/kbh_chan_if.sv */
`timescale 1ns/100ps
interface kbh_chan_if;
  logic       busy;
  logic       active;
  logic       tx_timeout;
  logic       rx_timeout;
  logic       clear;
  modport ctrl (output busy, output active, output clear, input tx_timeout, input rx_timeout);
  modport chan (input busy, input active, input clear, output tx_timeout, output rx_timeout);
endinterface

/* src/kbh_sync.sv */
`timescale 1ns/100ps
module kbh_sync
  import kbh_pkg::*;
#(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Asynchronous levels and their synchronised copies.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

/* src/kbh_timeout.sv */
`timescale 1ns/100ps
module kbh_timeout
  import kbh_pkg::*;
#(
  parameter int TICKS = KBH_TIMEOUT_TICKS
)
(
  // Clock and reset.
  input  wire logic  clk,
  input  wire logic  rst_n,
  // Serial channel control.
  kbh_chan_if.chan   ch,
  // Line activity seen on the channel clock.
  input  wire logic  line_edge
);
  logic [7:0] count_reg;
  logic       running_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_reg   <= 8'h00;
      running_reg <= 1'b0;
    end
    else if (!ch.active || !ch.busy || line_edge)
    begin
      count_reg   <= 8'h00;
      running_reg <= 1'b0;
    end
    else
    begin
      // Counting starts as soon as the channel is active and busy, not only after a line edge.
      running_reg <= 1'b1;
      if (count_reg != 8'(TICKS))
        count_reg <= count_reg + 8'h01;
    end
  end

  // Set wins over clear so a timeout in the clearing cycle is kept.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch.tx_timeout <= 1'b0;
      ch.rx_timeout <= 1'b0;
    end
    else
    begin
      if (running_reg && count_reg == 8'(TICKS - 1))
      begin
        ch.rx_timeout <= 1'b1;
        ch.tx_timeout <= 1'b1;
      end
      else if (ch.clear)
      begin
        ch.rx_timeout <= 1'b0;
        ch.tx_timeout <= 1'b0;
      end
    end
  end
endmodule

/* src/kbh_host_port.sv */
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
module kbh_host_port
  import kbh_pkg::*;
#(
  parameter int DELAY_CYC = KBH_DELAY_CYC
)
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Avalon-MM slave.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Host port pins.
  input  wire logic        host_cs_n,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic        host_a2,
  input  wire logic [7:0]  host_d_in,
  output logic      [7:0]  host_d_out,
  output logic             host_d_oe_n,
  // Keyswitch, parallel input and serial lines.
  input  wire logic        mgmt_interrupt_keyswitch_pin,
  input  wire logic [6:0]  input_port_pins,
  input  wire logic        kbd_clk_pin,
  input  wire logic        mouse_clk_pin,
  output logic             mouse_pins_active,
  // Internal system request input and outputs.
  input  wire logic        turbo_other_req,
  output logic             turbo_request,
  output logic             cpu_reset_pulse,
  output logic             address_line_gate
);
  logic       rst_n_meta_reg;
  logic       rst_n_reg;
  logic       cs_n_s, rd_n_s, wr_n_s, a2_s, key_s, kclk_s, mclk_s;
  logic [7:0] hd_s;
  logic [6:0] in_s;
  logic       rd_n_d_reg, wr_n_d_reg, kclk_d_reg, mclk_d_reg;
  logic [7:0] in_buf_reg, out_buf_reg, status_reg, output_port;
  logic [7:0] keyboard_control_register, misc_setup_register;
  logic [7:0] mgmt_interrupt_control_register, ram_addr_reg;
  logic [7:0] user_ram [32];
  logic       gate_armed_reg;
  kbh_rst_e   rst_state_reg;
  logic [15:0] rst_cnt_reg;
  logic       host_rd_ev, host_wr_ev, sw_rd, sw_wr;
  logic       rd_wait_reg;
  logic [7:0] input_port;
  kbh_chan_if kch ();
  kbh_chan_if mch ();

  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_n_meta_reg <= 1'b0;
      rst_n_reg      <= 1'b0;
    end
    else
    begin
      rst_n_meta_reg <= 1'b1;
      rst_n_reg      <= rst_n_meta_reg;
    end
  end

  // Strobes and serial clocks reset to their idle high level, so no false edge follows reset.
  kbh_sync #(.WIDTH(22), .RST_VAL({3'h7, 17'h00000, 2'h3})) u_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n_reg),
    .async_in ({host_cs_n, host_rd_n, host_wr_n, host_a2, host_d_in,
                mgmt_interrupt_keyswitch_pin, input_port_pins, kbd_clk_pin, mouse_clk_pin}),
    .sync_out ({cs_n_s, rd_n_s, wr_n_s, a2_s, hd_s, key_s, in_s, kclk_s, mclk_s})
  );

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rd_n_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
      kclk_d_reg <= 1'b1;
      mclk_d_reg <= 1'b1;
    end
    else
    begin
      rd_n_d_reg <= rd_n_s;
      wr_n_d_reg <= wr_n_s;
      kclk_d_reg <= kclk_s;
      mclk_d_reg <= mclk_s;
    end
  end

  assign host_rd_ev = !cs_n_s && !rd_n_s && rd_n_d_reg && wr_n_s;
  assign host_wr_ev = !cs_n_s && !wr_n_s && wr_n_d_reg && rd_n_s;
  // A read counts once, at the edge that ends its wait state.
  assign sw_rd      = avs_read && !avs_waitrequest;
  assign sw_wr      = avs_write;
  // Read data come from a flop, so each read waits one cycle; writes never wait.
  assign avs_waitrequest = avs_read && !rd_wait_reg;

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      rd_wait_reg <= 1'b0;
    else
      rd_wait_reg <= avs_read && !rd_wait_reg;
  end

  assign input_port = {mgmt_interrupt_control_register[KBH_BIT_MGMT] ? 1'b1 : key_s, in_s};
  assign mouse_pins_active = keyboard_control_register[KBH_BIT_PERS];
  assign turbo_request = output_port[2] | turbo_other_req;

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      host_d_out  <= 8'h00;
      host_d_oe_n <= 1'b1;
    end
    else
    begin
      host_d_oe_n <= !(!cs_n_s && !rd_n_s);
      host_d_out  <= a2_s ? status_reg : out_buf_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      status_reg <= KBH_STATUS_RST;
      in_buf_reg <= 8'h00;
    end
    else
    begin
      if (host_wr_ev)
      begin
        in_buf_reg                <= hd_s;
        status_reg[KBH_BIT_CMD]   <= a2_s;
        status_reg[KBH_BIT_IBF]   <= 1'b1;
      end
      else if (sw_rd && avs_address == KBH_OFF_MCU_IN)
        status_reg[KBH_BIT_IBF] <= 1'b0;
      if (sw_wr && avs_address == KBH_OFF_MCU_OUT)
        status_reg[KBH_BIT_OBF] <= 1'b1;
      else if (host_rd_ev && !a2_s)
        status_reg[KBH_BIT_OBF] <= 1'b0;
      if (sw_wr && avs_address == KBH_OFF_STATUS)
        status_reg[KBH_BIT_KBEN:KBH_BIT_SYS] <= avs_writedata[KBH_BIT_KBEN:KBH_BIT_SYS];
      // Clear goes first; a timeout still standing sets the bit again next cycle.
      if (kch.clear)
        status_reg[6] <= 1'b0;
      else if (kch.rx_timeout || mch.rx_timeout)
        status_reg[6] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      out_buf_reg                     <= 8'h00;
      keyboard_control_register       <= 8'h00;
      misc_setup_register             <= 8'h00;
      mgmt_interrupt_control_register <= 8'h00;
      ram_addr_reg                    <= 8'h00;
      output_port                     <= KBH_OUTPORT_RST;
    end
    else if (sw_wr)
    begin
      if (avs_address == KBH_OFF_MCU_OUT)
        out_buf_reg <= avs_writedata[7:0];
      else if (avs_address == KBH_OFF_KEYBOARD_CONTROL_REGISTER)
        keyboard_control_register <= avs_writedata[7:0];
      else if (avs_address == KBH_OFF_MISC)
        misc_setup_register <= avs_writedata[7:0];
      else if (avs_address == KBH_OFF_MGMT)
        mgmt_interrupt_control_register <= avs_writedata[7:0];
      else if (avs_address == KBH_OFF_RAM_ADDR)
        ram_addr_reg <= {3'b000, avs_writedata[4:0]};
      else if (avs_address == KBH_OFF_PORTS)
        output_port <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sw_wr && avs_address == KBH_OFF_RAM_DATA)
      user_ram[ram_addr_reg[4:0]] <= avs_writedata[7:0];
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      gate_armed_reg    <= 1'b0;
      address_line_gate <= 1'b1;
    end
    else if (host_wr_ev)
    begin
      if (a2_s)
        gate_armed_reg <= (hd_s == KBH_CMD_GATE);
      else
      begin
        if (gate_armed_reg)
          address_line_gate <= hd_s[KBH_GATE_BIT];
        gate_armed_reg <= 1'b0;
      end
    end
    // Firmware drives the gate through its port bit as well.
    else if (sw_wr && avs_address == KBH_OFF_PORTS)
      address_line_gate <= avs_writedata[KBH_GATE_BIT];
  end

  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
    begin
      rst_state_reg   <= KBH_RST_IDLE;
      rst_cnt_reg     <= 16'h0000;
      cpu_reset_pulse <= 1'b0;
    end
    else
    begin
      case (rst_state_reg)
        KBH_RST_IDLE:
        begin
          cpu_reset_pulse <= 1'b0;
          // The port bit triggers on the write itself; a level test would retrigger forever.
          if ((host_wr_ev && a2_s && hd_s == KBH_CMD_PULSE) ||
              (sw_wr && avs_address == KBH_OFF_PORTS && !avs_writedata[0]))
          begin
            rst_state_reg <= KBH_RST_WAIT;
            rst_cnt_reg   <= misc_setup_register[KBH_BIT_QUICK] ?
                             16'(KBH_QUICK_CYC - 1) : 16'(DELAY_CYC - 1);
          end
        end
        KBH_RST_WAIT:
        begin
          if (rst_cnt_reg == 16'h0000)
          begin
            rst_state_reg   <= KBH_RST_PULSE;
            rst_cnt_reg     <= 16'(KBH_PULSE_CYC - 1);
            cpu_reset_pulse <= 1'b1;
          end
          else
            rst_cnt_reg <= rst_cnt_reg - 16'h0001;
        end
        KBH_RST_PULSE:
        begin
          if (rst_cnt_reg == 16'h0000)
          begin
            rst_state_reg   <= KBH_RST_IDLE;
            cpu_reset_pulse <= 1'b0;
          end
          else
            rst_cnt_reg <= rst_cnt_reg - 16'h0001;
        end
        default:
          rst_state_reg <= KBH_RST_IDLE;
      endcase
    end
  end

  assign kch.busy   = status_reg[KBH_BIT_KBEN];
  assign kch.active = 1'b1;
  assign kch.clear  = sw_wr && avs_address == KBH_OFF_SERIAL;
  kbh_timeout u_kto (
    .clk       (sys_clk),
    .rst_n     (rst_n_reg),
    .ch        (kch.chan),
    .line_edge (kclk_s != kclk_d_reg)
  );

  assign mch.busy   = status_reg[KBH_BIT_KBEN];
  assign mch.active = keyboard_control_register[KBH_BIT_PERS];
  assign mch.clear  = kch.clear;
  kbh_timeout u_mto (
    .clk       (sys_clk),
    .rst_n     (rst_n_reg),
    .ch        (mch.chan),
    .line_edge (mclk_s != mclk_d_reg)
  );

  // Read data load during the wait state; unmapped offsets read zero.
  always_ff @(posedge sys_clk or negedge rst_n_reg)
  begin
    if (!rst_n_reg)
      avs_readdata <= 32'h0000_0000;
    else if (avs_address == KBH_OFF_DATA || avs_address == KBH_OFF_MCU_IN)
      avs_readdata <= {24'h000000, avs_address == KBH_OFF_DATA ? out_buf_reg : in_buf_reg};
    else if (avs_address == KBH_OFF_STATUS)
      avs_readdata <= {24'h000000, status_reg};
    else if (avs_address == KBH_OFF_KEYBOARD_CONTROL_REGISTER)
      avs_readdata <= {24'h000000, keyboard_control_register};
    else if (avs_address == KBH_OFF_MISC)
      avs_readdata <= {24'h000000, misc_setup_register};
    else if (avs_address == KBH_OFF_MGMT)
      avs_readdata <= {24'h000000, mgmt_interrupt_control_register};
    else if (avs_address == KBH_OFF_RAM_DATA)
      avs_readdata <= {24'h000000, user_ram[ram_addr_reg[4:0]]};
    else if (avs_address == KBH_OFF_PORTS)
      avs_readdata <= {16'h0000, input_port, output_port};
    else if (avs_address == KBH_OFF_SERIAL)
      avs_readdata <= {28'h0000000, mch.rx_timeout, mch.tx_timeout, kch.rx_timeout,
                       kch.tx_timeout};
    else
      avs_readdata <= 32'h0000_0000;
  end
endmodule

/* verification/kbh_host_model.sv */
`timescale 1ns/100ps
module kbh_host_model
(
  // Clock.
  input  wire logic       clk,
  // Host strobes and data.
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic            a2,
  output logic [7:0]      d_drv,
  input  wire logic [7:0] d_bus
);
  initial
  begin
    cs_n  = 1'b1;
    rd_n  = 1'b1;
    wr_n  = 1'b1;
    a2    = 1'b0;
    d_drv = 8'h00;
  end

  // Strobes are held well past the two-flop sync; released data lines show the inverse.
  task automatic cycle(input logic rd, input logic ad, input logic [7:0] wd,
                       output logic [7:0] rdv);
    cs_n  <= 1'b0;
    a2    <= ad;
    d_drv <= rd ? ~d_drv : wd;
    @(posedge clk);
    if (rd)
      rd_n <= 1'b0;
    else
      wr_n <= 1'b0;
    repeat (6) @(posedge clk);
    rdv = d_bus;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    @(posedge clk);
    cs_n  <= 1'b1;
    d_drv <= ~d_drv;
    repeat (4) @(posedge clk);
  endtask

  task automatic host_rd(input logic ad, output logic [7:0] rdv);
    cycle(1'b1, ad, 8'h00, rdv);
  endtask

  task automatic host_wr(input logic ad, input logic [7:0] wd);
    logic [7:0] s;
    int         n;
    n = 0;
    do
    begin
      cycle(1'b1, 1'b1, 8'h00, s);
      n++;
    end
    while (s[1] !== 1'b0 && n < 20);
    cycle(1'b0, ad, wd, s);
  endtask
endmodule

/* verification/kbh_host_port_props.sv */
`timescale 1ns/100ps
module kbh_props
  import kbh_pkg::*;
#(
  parameter int DELAY_CYC = 10
)
(
  // Clock, reset and register bus.
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Host strobes and data output enable.
  input wire logic        host_cs_n,
  input wire logic        host_rd_n,
  input wire logic        host_wr_n,
  input wire logic        host_d_oe_n,
  // Internal system request input and outputs.
  input wire logic        mouse_pins_active,
  input wire logic        turbo_other_req,
  input wire logic        turbo_request,
  input wire logic        cpu_reset_pulse,
  input wire logic        address_line_gate
);
  localparam logic [7:0] MIN_WAIT = 8'(DELAY_CYC < KBH_QUICK_CYC ? DELAY_CYC : KBH_QUICK_CYC);
  logic [7:0] hi_cnt_reg;
  logic [7:0] since_wr_reg;
  logic       wr_n_d_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      hi_cnt_reg <= 8'h00;
    else
      hi_cnt_reg <= cpu_reset_pulse ? hi_cnt_reg + 8'h01 : 8'h00;

  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      wr_n_d_reg <= 1'b1;
    else
      wr_n_d_reg <= host_wr_n;

  // Counts from the start of a host write or from a port write.
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      since_wr_reg <= 8'hff;
    else if ((!host_wr_n && wr_n_d_reg) || (avs_write && avs_address == KBH_OFF_PORTS))
      since_wr_reg <= 8'h00;
    else if (since_wr_reg != 8'hff)
      since_wr_reg <= since_wr_reg + 8'h01;

  write_nowait_a: assert property (avs_write |-> !avs_waitrequest)
    else $error("write held off");
  read_wait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  unmapped_zero_a: assert property (avs_read && avs_address > 4'ha |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  pers_follow_a: assert property (avs_write && avs_address == KBH_OFF_KEYBOARD_CONTROL_REGISTER
    |=> mouse_pins_active == $past(avs_writedata[KBH_BIT_PERS])) else $error("mouse pins wrong");
  turbo_merge_a: assert property (turbo_other_req |-> turbo_request)
    else $error("turbo request lost");
  pulse_width_a: assert property ($fell(cpu_reset_pulse) |-> hi_cnt_reg == KBH_PULSE_CYC)
    else $error("reset pulse width wrong");
  pulse_cap_a: assert property (hi_cnt_reg <= KBH_PULSE_CYC)
    else $error("reset pulse too long");
  pulse_delay_a: assert property ($rose(cpu_reset_pulse) |-> since_wr_reg >= MIN_WAIT)
    else $error("reset pulse too early");
  gate_cause_a: assert property ($changed(address_line_gate) |-> since_wr_reg <= 8'd8)
    else $error("gate moved without a write");
  oe_after_rd_a: assert property ($fell(host_d_oe_n) |-> !$past(host_rd_n, 2) && !$past(host_cs_n, 2))
    else $error("bus driven without read");
  oe_release_a: assert property ($rose(host_rd_n) |-> ##[1:5] host_d_oe_n)
    else $error("bus not released");
endmodule

bind kbh_host_port kbh_props #(.DELAY_CYC(DELAY_CYC)) props_u (.sys_clk, .resetn, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .host_cs_n,
  .host_rd_n, .host_wr_n, .host_d_oe_n, .mouse_pins_active, .turbo_other_req,
  .turbo_request, .cpu_reset_pulse, .address_line_gate);

/* verification/tb.sv */
`timescale 1ns/100ps
module tb
  import kbh_pkg::*;
;
  localparam int DLY = 10;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        host_cs_n, host_rd_n, host_wr_n, host_a2, host_d_oe_n;
  logic [7:0]  host_d_in, host_d_out, d_bus;
  logic        mgmt_interrupt_keyswitch_pin = 1'b0;
  logic [6:0]  input_port_pins = 7'h55;
  logic        kbd_clk_pin = 1'b1;
  logic        mouse_clk_pin = 1'b1;
  logic        mouse_pins_active, turbo_request, cpu_reset_pulse, address_line_gate;
  logic        turbo_other_req = 1'b0;
  logic [31:0] d;
  logic [7:0]  h;
  int          errors = 0;
  int          total_checks = 0;
  int          cyc = 0;

  assign d_bus = host_d_oe_n ? host_d_in : host_d_out;

  kbh_host_port #(.DELAY_CYC(DLY)) dut_u (.sys_clk, .resetn, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .host_cs_n, .host_rd_n,
    .host_wr_n, .host_a2, .host_d_in, .host_d_out, .host_d_oe_n,
    .mgmt_interrupt_keyswitch_pin, .input_port_pins, .kbd_clk_pin, .mouse_clk_pin,
    .mouse_pins_active, .turbo_other_req, .turbo_request, .cpu_reset_pulse,
    .address_line_gate);

  kbh_host_model host_u (.clk(sys_clk), .cs_n(host_cs_n), .rd_n(host_rd_n), .wr_n(host_wr_n),
    .a2(host_a2), .d_drv(host_d_in), .d_bus(d_bus));

  always #25 sys_clk = ~sys_clk;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      errors++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask

  task automatic av_wr(input logic [3:0] a, input logic [31:0] v);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= v;
    avs_write     <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  // The request stands until waitrequest is seen low; data are taken at that edge.
  task automatic av_rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    avs_address <= a;
    avs_read    <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    v = avs_readdata;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic s_flags();
    av_rd(KBH_OFF_STATUS, d);
    chk(d[7:0], KBH_STATUS_RST);
    chk(address_line_gate, 1'b1);
    host_u.host_wr(1'b0, 8'h3c);
    av_rd(KBH_OFF_STATUS, d);
    chk(d[7:0], 8'h12);
    av_rd(KBH_OFF_MCU_IN, d);
    chk(d[7:0], 8'h3c);
    av_rd(KBH_OFF_STATUS, d);
    chk(d[7:0], 8'h10);
    host_u.host_wr(1'b1, 8'h5a);
    av_rd(KBH_OFF_STATUS, d);
    chk(d[7:0], 8'h1a);
    av_rd(KBH_OFF_MCU_IN, d);
    chk(d[7:0], 8'h5a);
    av_wr(KBH_OFF_MCU_OUT, 32'ha7);
    host_u.host_rd(1'b1, h);
    chk(h, 8'h19);
    host_u.host_rd(1'b1, h);
    chk(h, 8'h19);
    host_u.host_rd(1'b0, h);
    chk(h, 8'ha7);
    host_u.host_rd(1'b1, h);
    chk(h, 8'h18);
  endtask

  task automatic s_gate(input logic [7:0] v, input logic exp);
    host_u.host_wr(1'b1, KBH_CMD_GATE);
    av_rd(KBH_OFF_MCU_IN, d);
    host_u.host_wr(1'b0, v);
    av_rd(KBH_OFF_MCU_IN, d);
    chk(address_line_gate, exp);
  endtask

  task automatic s_pulse(input int lo);
    int n;
    int w;
    fork
      host_u.host_wr(1'b1, KBH_CMD_PULSE);
      begin
        n = 0;
        w = 0;
        wait (host_wr_n === 1'b0);
        while (cpu_reset_pulse !== 1'b1 && n < 400)
        begin
          @(posedge sys_clk);
          n++;
        end
        chk(n >= lo && n <= lo + 5, 1'b1);
        while (cpu_reset_pulse === 1'b1 && w < 400)
        begin
          w++;
          @(posedge sys_clk);
        end
        chk(w, KBH_PULSE_CYC);
      end
    join
    av_rd(KBH_OFF_MCU_IN, d);
  endtask

  task automatic s_regs();
    av_wr(KBH_OFF_KEYBOARD_CONTROL_REGISTER, 32'h2);
    chk(mouse_pins_active, 1'b1);
    av_wr(KBH_OFF_KEYBOARD_CONTROL_REGISTER, 32'h0);
    chk(mouse_pins_active, 1'b0);
    av_wr(KBH_OFF_PORTS, 32'h05);
    chk(turbo_request, 1'b1);
    chk(address_line_gate, 1'b0);
    av_wr(KBH_OFF_PORTS, 32'hff03);
    chk(turbo_request, 1'b0);
    chk(address_line_gate, 1'b1);
    turbo_other_req <= 1'b1;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk(turbo_request, 1'b1);
    turbo_other_req <= 1'b0;
    av_rd(KBH_OFF_PORTS, d);
    chk(d[15:0], 16'h5503);
    av_wr(KBH_OFF_MGMT, 32'h80);
    av_rd(KBH_OFF_PORTS, d);
    chk(d[15], 1'b1);
    av_rd(4'hf, d);
    chk(d, 32'h0);
    av_wr(KBH_OFF_RAM_ADDR, 32'h25);
    av_wr(KBH_OFF_RAM_DATA, 32'h96);
    av_wr(KBH_OFF_RAM_ADDR, 32'h06);
    av_wr(KBH_OFF_RAM_DATA, 32'h69);
    av_wr(KBH_OFF_RAM_ADDR, 32'h05);
    av_rd(KBH_OFF_RAM_DATA, d);
    chk(d[7:0], 8'h96);
  endtask

  // The keyboard line has been idle since reset, so its timer has long expired.
  task automatic s_serial();
    av_rd(KBH_OFF_SERIAL, d);
    chk(d[3:0], 4'h3);
    av_rd(KBH_OFF_STATUS, d);
    chk(d[6], 1'b1);
    av_wr(KBH_OFF_SERIAL, 32'h0);
    av_rd(KBH_OFF_SERIAL, d);
    chk(d[3:0], 4'h0);
    av_rd(KBH_OFF_STATUS, d);
    chk(d[6], 1'b0);
    av_wr(KBH_OFF_KEYBOARD_CONTROL_REGISTER, 32'h2);
    repeat (260) @(posedge sys_clk);
    av_rd(KBH_OFF_SERIAL, d);
    chk(d[3:0], 4'hc);
    av_wr(KBH_OFF_KEYBOARD_CONTROL_REGISTER, 32'h0);
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    s_flags();
    s_gate(8'h01, 1'b0);
    s_gate(8'h03, 1'b1);
    s_pulse(DLY);
    av_wr(KBH_OFF_MISC, 32'h20);
    s_pulse(KBH_QUICK_CYC);
    s_regs();
    s_serial();
    report_and_stop();
  end
endmodule
